// ### hw/warning_status_defines.vh
`ifndef WARNING_STATUS_DEFINES_VH
`define WARNING_STATUS_DEFINES_VH

// Parameter addresses on the fieldbus parameter interface
`define ADDR_ACTIVE_WARNING_WORD  16'h1C16
`define ADDR_LATCHED_WARNING_WORD 16'h1C18

// Bit positions shared by both warning words
`define WARN_GENERAL        0
`define WARN_STAGE_TEMP     1
`define WARN_MOTOR_TEMP     2
`define WARN_RSVD3          3
`define WARN_STAGE_I2T      4
`define WARN_MOTOR_I2T      5
`define WARN_BRAKE_I2T      6
`define WARN_CAN            7
`define WARN_ENCODER        8
`define WARN_RS485          9
`define WARN_SAFE_TORQUE    10
`define WARN_DC_BUS         11
`define WARN_PROFIBUS       12
`define WARN_POS_CAPTURE    13
`define WARN_ETHERNET       14
`define WARN_RSVD15         15

// Latched bits that follow their condition instead of waiting for a clear
`define WARN_SELF_CLEAR_MASK 16'h2C00
// Bits that never set
`define WARN_RESERVED_MASK   16'h8008
`define WARN_WORD_ZERO       16'h0000

`endif

// ### hw/warning_status_words.v
`timescale 1ns/1ps
`default_nettype none
`include "warning_status_defines.vh"

module warning_status_words #(
  parameter ADDR_WIDTH = 16,
  parameter DATA_WIDTH = 16
) (
  input  wire                  clk,
  input  wire                  reset,
  input  wire                  generalWarning,
  input  wire                  stageTempHigh,
  input  wire                  motorTempHigh,
  input  wire                  stageOverload,
  input  wire                  motorOverload,
  input  wire                  brakeOverload,
  input  wire                  canWarning,
  input  wire                  encoderWarning,
  input  wire                  rs485Warning,
  input  wire                  safe_torque_input_a,
  input  wire                  safe_torque_input_b,
  input  wire                  dcBusUndervoltage,
  input  wire                  mainsPhaseMissing,
  input  wire                  profibusWarning,
  input  wire                  positionCaptureBusy,
  input  wire                  ethernetWarning,
  input  wire                  fault_clear_command,
  input  wire                  readStrobe,
  input  wire [ADDR_WIDTH-1:0] readAddress,
  output reg  [DATA_WIDTH-1:0] readData,
  output reg                   readValid,
  output reg                   readError,
  output wire [DATA_WIDTH-1:0] active_warning_word,
  output wire [DATA_WIDTH-1:0] latched_warning_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Safe torque inputs come from pins: two flops before use
  reg [1:0] stoASync_reg;
  reg [1:0] stoBSync_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      // Synchroniser rests high so no false warning shows in the first cycles after reset
      stoASync_reg <= 2'h3;
      stoBSync_reg <= 2'h3;
    end else begin
      stoASync_reg <= {stoASync_reg[0], safe_torque_input_a};
      stoBSync_reg <= {stoBSync_reg[0], safe_torque_input_b};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition word, assembled per bit
  reg [DATA_WIDTH-1:0] condition;

  always @* begin
    condition = `WARN_WORD_ZERO;
    condition[`WARN_GENERAL]     = generalWarning;
    condition[`WARN_STAGE_TEMP]  = stageTempHigh;
    condition[`WARN_MOTOR_TEMP]  = motorTempHigh;
    condition[`WARN_STAGE_I2T]   = stageOverload;
    condition[`WARN_MOTOR_I2T]   = motorOverload;
    condition[`WARN_BRAKE_I2T]   = brakeOverload;
    condition[`WARN_CAN]         = canWarning;
    condition[`WARN_ENCODER]     = encoderWarning;
    condition[`WARN_RS485]       = rs485Warning;
    condition[`WARN_SAFE_TORQUE] = ~stoASync_reg[1] | ~stoBSync_reg[1];
    condition[`WARN_DC_BUS]      = dcBusUndervoltage | mainsPhaseMissing;
    condition[`WARN_PROFIBUS]    = profibusWarning;
    condition[`WARN_POS_CAPTURE] = positionCaptureBusy;
    condition[`WARN_ETHERNET]    = ethernetWarning;
    condition = condition & ~`WARN_RESERVED_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active and latched words
  reg [DATA_WIDTH-1:0] active_reg;
  reg [DATA_WIDTH-1:0] latched_reg;
  reg [DATA_WIDTH-1:0] latched_next;
  reg [DATA_WIDTH-1:0] held;

  always @* begin
    held = latched_reg;
    if (fault_clear_command) begin
      held = `WARN_WORD_ZERO;
    end
    // Self-clearing bits simply track the condition
    held = held & ~`WARN_SELF_CLEAR_MASK;
    // Set wins over clear so an event in the clear cycle is kept
    latched_next = (held | condition) & ~`WARN_RESERVED_MASK;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      active_reg  <= `WARN_WORD_ZERO;
      latched_reg <= `WARN_WORD_ZERO;
    end else begin
      active_reg  <= condition;
      latched_reg <= latched_next;
    end
  end

  assign active_warning_word  = active_reg;
  assign latched_warning_word = latched_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter read port: one cycle after the strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      readData  <= `WARN_WORD_ZERO;
      readValid <= 1'b0;
      readError <= 1'b0;
    end else begin
      readValid <= readStrobe;
      readError <= 1'b0;
      if (readStrobe) begin
        case (readAddress)
          `ADDR_ACTIVE_WARNING_WORD: begin
            readData <= active_reg;
          end
          `ADDR_LATCHED_WARNING_WORD: begin
            readData <= latched_reg;
          end
          default: begin
            // Unmapped addresses answer zero with an error flag
            readData  <= `WARN_WORD_ZERO;
            readError <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/warning_status_words_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module warning_status_monitor (
  input wire logic        clk, reset, fault_clear_command, positionCaptureBusy,
  input wire logic        generalWarning, stageTempHigh, motorTempHigh,
  input wire logic        stageOverload, motorOverload, brakeOverload,
  input wire logic [15:0] active_warning_word, latched_warning_word
);
  wire logic [15:0] aw = active_warning_word;
  wire logic [15:0] lw = latched_warning_word;
  wire logic [2:0]  base = {motorTempHigh, stageTempHigh, generalWarning};
  wire logic [2:0]  load = {brakeOverload, motorOverload, stageOverload};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  base_bits_a: assert property (!$past(reset) |-> aw[2:0] == $past(base))
    else $error("base warning bits wrong");
  overload_bits_a: assert property (!$past(reset) |-> aw[6:4] == $past(load))
    else $error("overload bits wrong");
  capture_bit_a: assert property (!$past(reset) |-> aw[13] == $past(positionCaptureBusy))
    else $error("capture bit wrong");
  reserved_zero_a: assert property (((aw | lw) & 16'h8008) == 16'h0)
    else $error("reserved bit set");
  self_clear_a: assert property ((lw & 16'h2C00) == (aw & 16'h2C00))
    else $error("self clearing bit wrong");
  latch_set_a: assert property ((aw & ~lw & 16'h53F7) == 16'h0)
    else $error("active bit not latched");
  latch_hold_a: assert property (!fault_clear_command |=> ($past(lw) & ~lw & 16'h53F7) == 16'h0)
    else $error("latched bit dropped");
  clear_all_a: assert property (fault_clear_command |=> (lw & ~aw & 16'h53F7) == 16'h0)
    else $error("latched bit survived clear");
endmodule
bind warning_status_words warning_status_monitor mon (.clk, .reset, .fault_clear_command,
  .positionCaptureBusy, .generalWarning, .stageTempHigh, .motorTempHigh, .stageOverload,
  .motorOverload, .brakeOverload, .active_warning_word, .latched_warning_word);
`default_nettype wire

// ### verif/param_master.sv
`timescale 1ns/1ps
`default_nettype none
module param_master (
  input  wire logic        clk, readValid, readError,
  input  wire logic [15:0] readData,
  output var  logic        readStrobe = 1'b0,
  output var  logic [15:0] readAddress = 16'h0000
);
  // Released address shows its inverse so a stale decode cannot pass
  task readWord(input logic [15:0] a, output logic [17:0] r);
    @(negedge clk);
    {readStrobe, readAddress} = {1'b1, a};
    @(negedge clk);
    {readStrobe, readAddress} = {1'b0, ~a};
    r = {readValid, readError, readData};
  endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "warning_status_defines.vh"
module tb;
  logic        clk = 1'b0, reset = 1'b1, stoA = 1'b1, stoB = 1'b1, mains = 1'b0;
  logic        fault_clear_command = 1'b0;
  logic [15:0] cw = 16'h0000;
  wire logic   readStrobe, readValid, readError;
  wire logic [15:0] readAddress, readData;
  int          n_fail = 0, samples_checked = 0, cycles = 0;
  initial forever #2.5 clk = ~clk;
  warning_status_words dut (.clk, .reset, .generalWarning(cw[0]), .stageTempHigh(cw[1]),
    .motorTempHigh(cw[2]), .stageOverload(cw[4]), .motorOverload(cw[5]), .brakeOverload(cw[6]),
    .canWarning(cw[7]), .encoderWarning(cw[8]), .rs485Warning(cw[9]), .safe_torque_input_a(stoA),
    .safe_torque_input_b(stoB), .dcBusUndervoltage(cw[11]), .mainsPhaseMissing(mains),
    .profibusWarning(cw[12]), .positionCaptureBusy(cw[13]), .ethernetWarning(cw[14]),
    .fault_clear_command, .readStrobe, .readAddress, .readData, .readValid, .readError,
    .active_warning_word(), .latched_warning_word());
  param_master master (.clk, .readValid, .readError, .readData, .readStrobe, .readAddress);
  task readCheck(input logic [15:0] a, input logic [17:0] exp);
    logic [17:0] r;
    master.readWord(a, r);
    samples_checked++;
    if (r !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, r, exp);
    end
  endtask
  task expectWords(input logic [15:0] act, lat);
    readCheck(`ADDR_ACTIVE_WARNING_WORD, {2'h2, act});
    readCheck(`ADDR_LATCHED_WARNING_WORD, {2'h2, lat});
  endtask
  // Three edges cover the pin synchroniser plus the word register
  task apply(input logic [15:0] w, input logic a, b, m, clr);
    @(negedge clk);
    {cw, stoA, stoB, mains, fault_clear_command} = {w, a, b, m, clr};
    @(negedge clk);
    fault_clear_command = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task print_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) if (++cycles == 2000) begin n_fail++; print_verdict; end
  initial begin
    logic [15:0] sticky, e, lat;
    sticky = 16'h0000;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    expectWords(16'h0000, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      e = (16'h0001 << i) & ~`WARN_RESERVED_MASK;
      apply(16'h0001 << i, i != 10, 1'b1, 1'b0, 1'b0);
      sticky |= e & ~`WARN_SELF_CLEAR_MASK;
      lat = sticky | e & `WARN_SELF_CLEAR_MASK;
      expectWords(e, lat);
    end
    apply(16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
    expectWords(16'h0400, sticky | 16'h0400);
    apply(16'h0000, 1'b1, 1'b1, 1'b1, 1'b0);
    expectWords(16'h0800, sticky | 16'h0800);
    apply(16'h0002, 1'b1, 1'b1, 1'b0, 1'b1);
    expectWords(16'h0002, 16'h0002);
    readCheck(16'h1C17, 18'h30000);
    print_verdict;
  end
endmodule
`default_nettype wire
